// >>> inc/rgs_map.svh
`ifndef RGS_MAP_SVH
`define RGS_MAP_SVH

// Register byte offsets on the APB.
`define RGS_OFF_CTRL 8'h00
`define RGS_OFF_SEL 8'h04
`define RGS_OFF_OSLEN 8'h08
`define RGS_OFF_STAT 8'h0c

// Field positions in ramp_control_reg0.
`define RGS_CTRL_EN 0
`define RGS_CTRL_MODE_LSB 1
`define RGS_CTRL_MODE_MSB 2
`define RGS_CTRL_ONE_PULSE 3
`define RGS_CTRL_RISE_EDGE 4
`define RGS_CTRL_FALL_EDGE 5
`define RGS_CTRL_RISE_INV 6
`define RGS_CTRL_FALL_INV 7

// Field positions in the source select register.
`define RGS_SEL_RISE_LSB 0
`define RGS_SEL_RISE_MSB 3
`define RGS_SEL_FALL_LSB 8
`define RGS_SEL_FALL_MSB 11

// Field positions in the status register.
`define RGS_STAT_SHORT 0
`define RGS_STAT_SRC 1
`define RGS_STAT_SINK 2
`define RGS_STAT_OS_BUSY 3
`define RGS_STAT_DIR_UP 4
`define RGS_STAT_RISE_LVL 5
`define RGS_STAT_FALL_LVL 6

// Reset values.
`define RGS_CTRL_RST 8'h00
`define RGS_SEL_RST 16'h0000

// Timing of the one-shot.
`define RGS_CLK_PERIOD_NS 50
`define RGS_ONE_PULSE_NS 50
`define RGS_ONE_PULSE_CYC \
  ((`RGS_ONE_PULSE_NS + `RGS_CLK_PERIOD_NS - 1) / `RGS_CLK_PERIOD_NS)

`endif

// >>> inc/rgs_pkg.sv
package rgs_pkg;

  // Ramp mode field of ramp_control_reg0.
  typedef enum logic [1:0] {
    rgs_mode_fall,
    rgs_mode_rise,
    rgs_mode_alt,
    rgs_mode_spare
  } rgs_mode_t;

  // Direction of the alternating ramp.
  typedef enum logic {
    rgs_dir_up,
    rgs_dir_down
  } rgs_dir_t;

endpackage

// >>> core/rgs_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rgs_sync (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic d, // Asynchronous input.
  output logic q // Filtered, synchronised level.
);

  logic s1;
  logic s2;
  logic s3;

  // Three stages; the output moves only once stages two and three agree,
  // which also rejects a single-cycle glitch that slips past stage one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end

endmodule

`default_nettype wire

// >>> core/rgs_ramp_ctrl.sv
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rgs_map.svh"

module rgs_ramp_ctrl (
  input wire logic pclk, // System clock, 20 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB write byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic [3:0] cmp_out, // Comparator outputs.
  input wire logic [3:0] pwm_out, // PWM outputs.
  input wire logic [7:0] pin_in, // I/O pin levels.
  output logic ramp_short, // Capacitor shorting switch closed.
  output logic ramp_src_en, // Current source enabled.
  output logic ramp_sink_en // Current sink enabled.
);

  // Software-visible registers. Only the index bits of the select word
  // are stored; its other bits read as zero, so no flop sits unused.
  logic [7:0] ramp_control_reg0;
  logic [3:0] rise_sel;
  logic [3:0] fall_sel;
  logic [7:0] one_pulse_len;

  // Bus decode. Writes land on the access edge only; the setup cycle is
  // spent capturing read data, so a read shows the state one cycle before
  // its access edge.
  wire bus_setup = psel & ~penable;
  wire bus_write = psel & penable & pwrite;
  wire hit_ctrl = (paddr == `RGS_OFF_CTRL);
  wire hit_sel = (paddr == `RGS_OFF_SEL);
  wire hit_oslen = (paddr == `RGS_OFF_OSLEN);
  wire hit_stat = (paddr == `RGS_OFF_STAT);
  wire hit_any = hit_ctrl | hit_sel | hit_oslen | hit_stat;
  wire wr_ctrl = bus_write & hit_ctrl & pstrb[0];
  wire wr_sel_lo = bus_write & hit_sel & pstrb[0];
  wire wr_sel_hi = bus_write & hit_sel & pstrb[1];
  wire wr_oslen = bus_write & hit_oslen & pstrb[0];

  // Zero-wait slave: every access completes in its first access cycle.
  // Nothing here needs time to answer, so wait states would only cost.
  assign pready = 1'b1;

  // Control fields.
  wire ctl_enable = ramp_control_reg0[`RGS_CTRL_EN];
  wire one_pulse_enable = ramp_control_reg0[`RGS_CTRL_ONE_PULSE];
  wire rise_input_edge_select = ramp_control_reg0[`RGS_CTRL_RISE_EDGE];
  wire fall_input_edge_select = ramp_control_reg0[`RGS_CTRL_FALL_EDGE];
  wire rise_invert = ramp_control_reg0[`RGS_CTRL_RISE_INV];
  wire fall_invert = ramp_control_reg0[`RGS_CTRL_FALL_INV];
  wire [3:0] rise_src_idx = rise_sel;
  wire [3:0] fall_src_idx = fall_sel;

  // Mode decode; the spare code behaves as the falling ramp, so no
  // setting can leave the switches in an undefined combination.
  rgs_pkg::rgs_mode_t mode;
  assign mode = rgs_pkg::rgs_mode_t'(
    ramp_control_reg0[`RGS_CTRL_MODE_MSB:`RGS_CTRL_MODE_LSB]);
  wire mode_alt = (mode == rgs_pkg::rgs_mode_alt);
  wire mode_rise = (mode == rgs_pkg::rgs_mode_rise);

  // Control register write, byte lane 0 only. A new mode acts at the next
  // edge with no hand-over, so software should disable before changing it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_control_reg0 <= `RGS_CTRL_RST;
    end else if (wr_ctrl) begin
      ramp_control_reg0 <= pwdata[7:0];
    end
  end

  // Rise source index, written through byte lane 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_sel <= 4'(`RGS_SEL_RST);
    end else if (wr_sel_lo) begin
      rise_sel <= pwdata[`RGS_SEL_RISE_MSB:`RGS_SEL_RISE_LSB];
    end
  end

  // Fall source index, written through byte lane 1.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_sel <= 4'(`RGS_SEL_RST >> `RGS_SEL_FALL_LSB);
    end else if (wr_sel_hi) begin
      fall_sel <= pwdata[`RGS_SEL_FALL_MSB:`RGS_SEL_FALL_LSB];
    end
  end

  // One-shot length in pclk cycles; zero is stored but used as one,
  // so the switch can never be released with no hold at all.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_pulse_len <= 8'(`RGS_ONE_PULSE_CYC);
    end else if (wr_oslen) begin
      one_pulse_len <= pwdata[7:0];
    end
  end

  // All timing sources in one vector: comparators, PWMs, then pins.
  // Four index bits cover all sixteen, so no index can fall outside.
  wire [15:0] src_vec = {pin_in, pwm_out, cmp_out};
  wire rise_raw = src_vec[rise_src_idx];
  wire fall_raw = src_vec[fall_src_idx];

  // The selection is made before the synchroniser, so a reselect glitch
  // is filtered like any other asynchronous change. Each path costs four
  // cycles of latency, three stages and the agreement; a source pulse
  // under two cycles wide may be lost.
  logic rise_sync;
  logic fall_sync;

  rgs_sync u_rise_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(rise_raw),
    .q(rise_sync)
  );

  rgs_sync u_fall_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(fall_raw),
    .q(fall_sync)
  );

  // Polarity applied after synchronisation so one source can drive both.
  // Inverting after the filter keeps the latency of both paths identical.
  wire rise_lvl = rise_sync ^ rise_invert;
  wire fall_lvl = fall_sync ^ fall_invert;

  // Previous samples for edge detection. They reset low to match an idle,
  // non-inverted input; setting an inversion bit while the block runs
  // is therefore seen as an edge.
  logic rise_prev;
  logic fall_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_prev <= 1'b0;
      fall_prev <= 1'b0;
    end else begin
      rise_prev <= rise_lvl;
      fall_prev <= fall_lvl;
    end
  end

  // Assertion edges compare consecutive post-inversion samples.
  // Only the asserting change counts; a release is no event.
  wire rise_edge = rise_lvl & ~rise_prev;
  wire fall_edge = fall_lvl & ~fall_prev;

  // One-shot counter state. The count starts on the trigger edge, so the
  // hold lasts the length plus that edge and never falls short of the
  // minimum, at the cost of one extra cycle.
  logic [7:0] os_cnt;
  wire os_busy = (os_cnt != 8'h00);
  wire [7:0] os_load = (one_pulse_len == 8'h00) ? 8'h01 : one_pulse_len;

  // Requests: edges are lost while the one-shot runs, levels just wait.
  // Gating here, ahead of both mode paths, keeps the hold alike in both.
  wire rise_sense = rise_input_edge_select ? rise_edge : rise_lvl;
  wire fall_sense = fall_input_edge_select ? fall_edge : fall_lvl;
  wire rise_req = rise_sense & ~os_busy;
  wire fall_req = fall_sense & ~os_busy;

  // Ramp state.
  logic short_q;
  logic charge_q;
  rgs_pkg::rgs_dir_t dir;
  logic next_short;
  logic next_charge;
  rgs_pkg::rgs_dir_t next_dir;
  logic alt_turn;

  // Rise/fall modes: the fall request discharges the capacitor back to
  // the input level; an edge-sensitive input latches its action until
  // the opposite request, a level input acts only while it is held.
  // Busy is tested before the requests, so the hold overrides a rise.
  always_comb begin
    next_short = 1'b0;
    next_charge = 1'b0;
    if (!ctl_enable || mode_alt) begin
      next_short = 1'b0;
      next_charge = 1'b0;
    end else if (os_busy) begin
      next_short = 1'b1;
      next_charge = 1'b0;
    end else if (fall_req) begin
      next_short = 1'b1;
      next_charge = 1'b0;
    end else if (rise_req) begin
      next_short = 1'b0;
      next_charge = 1'b1;
    end else begin
      next_short = fall_input_edge_select & short_q;
      next_charge = rise_input_edge_select & charge_q;
    end
  end

  // Alternating mode: turn down on a fall request, up on a rise request.
  // No other state is kept, so a disable always restarts the ramp upward;
  // the one-shot gates both requests so each ramp has its minimum length.
  always_comb begin
    next_dir = dir;
    alt_turn = 1'b0;
    if (!ctl_enable || !mode_alt) begin
      next_dir = rgs_pkg::rgs_dir_up;
    end else begin
      case (dir)
        rgs_pkg::rgs_dir_up: begin
          if (fall_req) begin
            next_dir = rgs_pkg::rgs_dir_down;
            alt_turn = 1'b1;
          end
        end
        rgs_pkg::rgs_dir_down: begin
          if (rise_req) begin
            next_dir = rgs_pkg::rgs_dir_up;
            alt_turn = 1'b1;
          end
        end
        default: begin
          next_dir = rgs_pkg::rgs_dir_up;
        end
      endcase
    end
  end

  // A one-shot starts on each discharge or, in alternating mode, on each
  // change of direction, and only when software has enabled it.
  // A trigger while busy cannot occur, as busy gates every request.
  wire os_trigger = mode_alt ? alt_turn : fall_req;
  wire os_start = ctl_enable & one_pulse_enable & os_trigger;

  // One-shot down-counter on pclk.
  // Eight bits cover up to 255 cycles, far past the minimum hold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_cnt <= 8'h00;
    end else if (os_start) begin
      os_cnt <= os_load;
    end else if (os_busy) begin
      os_cnt <= os_cnt - 8'h01;
    end
  end

  // State registers. Direction resets to up, so an alternating ramp
  // always begins by charging.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_q <= 1'b0;
      charge_q <= 1'b0;
      dir <= rgs_pkg::rgs_dir_up;
    end else begin
      short_q <= next_short;
      charge_q <= next_charge;
      dir <= next_dir;
    end
  end

  // Output drive: the rising mode charges with the source, the falling
  // mode with the sink; alternating mode picks by direction and never
  // shorts the capacitor. Both currents come from next-state terms, so
  // they move on the same edge as the switch.
  wire alt_up = ctl_enable & mode_alt & (next_dir == rgs_pkg::rgs_dir_up);
  wire alt_down = ctl_enable & mode_alt & (next_dir == rgs_pkg::rgs_dir_down);
  wire next_src = alt_up | (next_charge & mode_rise);
  wire next_sink = alt_down | (next_charge & ~mode_rise);

  // Outputs are registered so the analog switches see no decode glitch.
  // The price is one cycle of latency after the request is decided.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_short <= 1'b0;
      ramp_src_en <= 1'b0;
      ramp_sink_en <= 1'b0;
    end else begin
      ramp_short <= next_short & ~mode_alt;
      ramp_src_en <= next_src;
      ramp_sink_en <= next_sink;
    end
  end

  // Status word reflecting live block state. Like every read it is taken
  // in the setup cycle, so what software sees is one bus cycle old.
  logic [31:0] stat_word;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`RGS_STAT_SHORT] = ramp_short;
    stat_word[`RGS_STAT_SRC] = ramp_src_en;
    stat_word[`RGS_STAT_SINK] = ramp_sink_en;
    stat_word[`RGS_STAT_OS_BUSY] = os_busy;
    stat_word[`RGS_STAT_DIR_UP] = (dir == rgs_pkg::rgs_dir_up);
    stat_word[`RGS_STAT_RISE_LVL] = rise_lvl;
    stat_word[`RGS_STAT_FALL_LVL] = fall_lvl;
  end

  // Read data selection; unmapped offsets read as zero.
  // Reserved bits are tied low here rather than in each register.
  wire [31:0] rd_ctrl = {24'h000000, ramp_control_reg0};
  wire [31:0] rd_sel = {16'h0000, 4'h0, fall_src_idx, 4'h0, rise_src_idx};
  wire [31:0] rd_oslen = {24'h000000, one_pulse_len};
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                       hit_sel ? rd_sel :
                       hit_oslen ? rd_oslen :
                       hit_stat ? stat_word : 32'h0000_0000;

  // Read data and error are captured in the setup cycle, so they are
  // stable from flip-flops for the whole access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (bus_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~hit_any;
    end
  end

endmodule

`default_nettype wire

// >>> test/rgs_ramp_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "rgs_map.svh"
module rgs_ramp_ctrl_chk (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Access phase.
  input wire logic pwrite, // Direction.
  input wire logic [7:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [3:0] pstrb, // Strobes.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic ramp_short, // Shorting switch.
  input wire logic ramp_src_en, // Source.
  input wire logic ramp_sink_en // Sink.
);
  logic acc, hit, wr_ctrl;
  logic [7:0] ctrl_h;
  // Access decode; the mapped set is the four register offsets.
  assign acc = psel && penable;
  assign hit = paddr inside {`RGS_OFF_CTRL, `RGS_OFF_SEL,
    `RGS_OFF_OSLEN, `RGS_OFF_STAT};
  assign wr_ctrl = acc && pwrite && pstrb[0] && paddr == `RGS_OFF_CTRL;
  // Shadow of the control byte, so the mode is known without the body.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_h <= 8'h00;
    else if (wr_ctrl) ctrl_h <= pwdata[7:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (pready)
    else $error("pready low");
  unmap_err_a: assert property (acc && !hit |-> pslverr)
    else $error("unmapped access not refused");
  unmap_rd_a: assert property (acc && !hit && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  map_ok_a: assert property (acc && hit |-> !pslverr)
    else $error("mapped access refused");
  ctrl_rd_a: assert property (acc && !pwrite && paddr == `RGS_OFF_CTRL
    |-> prdata == {24'h0, ctrl_h}) else $error("control readback wrong");
  fall_wins_a: assert property (
    ramp_short |-> !ramp_src_en && !ramp_sink_en)
    else $error("current on while shorted");
  one_way_a: assert property (
    !(ramp_src_en && ramp_sink_en)) else $error("source and sink both on");
  off_idle_a: assert property ((!ctrl_h[0]) [*3]
    |-> !ramp_short && !ramp_src_en && !ramp_sink_en)
    else $error("output active while disabled");
  alt_open_a: assert property (
    (ctrl_h[0] && ctrl_h[2:1] == 2'h2) [*3] |-> !ramp_short)
    else $error("short closed in alternating mode");
endmodule
`default_nettype wire

// >>> test/rgs_ramp_cap.sv
`timescale 1ns/1ps
`default_nettype none
module rgs_ramp_cap (
  input wire logic pclk, // Step clock.
  input wire logic ramp_short, // Switch closed.
  input wire logic ramp_src_en, // Source on.
  input wire logic ramp_sink_en, // Sink on.
  output var int level // Steps away from the input level.
);
  // The short wins: it dumps the charge far faster than either current.
  initial level = 0;
  always @(posedge pclk) begin
    if (ramp_short) level <= 0;
    else if (ramp_src_en) level <= level + 1;
    else if (ramp_sink_en) level <= level - 1;
  end
endmodule
`default_nettype wire

// >>> test/rgs_ramp_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rgs_map.svh"
module rgs_ramp_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic ramp_short, ramp_src_en, ramp_sink_en;
  logic [7:0] paddr, lfsr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic [15:0] srcv, m;
  logic [2:0] cur;
  wire logic [2:0] outs;
  int fail_count, compares, level, k, n, c;
  assign outs = {ramp_sink_en, ramp_src_en, ramp_short};
  rgs_ramp_ctrl rgs_ramp_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_out(srcv[3:0]), .pwm_out(srcv[7:4]),
    .pin_in(srcv[15:8]), .ramp_short(ramp_short),
    .ramp_src_en(ramp_src_en), .ramp_sink_en(ramp_sink_en));
  rgs_ramp_cap rgs_ramp_cap_inst (.pclk(pclk), .ramp_short(ramp_short),
    .ramp_src_en(ramp_src_en), .ramp_sink_en(ramp_sink_en), .level(level));
  // Clock at 20 MHz.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Level model as {sink, src, short}; the fall request always wins.
  function automatic logic [2:0] model(input int md, input int r, int f);
    if (f != 0) return 3'b001;
    if (r == 0) return 3'b000;
    return (md == 1) ? 3'b010 : 3'b100;
  endfunction
  task automatic chk_reg(input string what, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_out(input logic [2:0] e);
    chk_reg("outputs", {29'h0, e}, {29'h0, outs});
  endtask
  // One transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Disable first so latched requests and direction start clean.
  task automatic setup(input logic [7:0] cb, logic [15:0] iv, logic [2:0] e);
    srcv <= iv;
    apb(1'b1, `RGS_OFF_CTRL, 32'h0);
    apb(1'b1, `RGS_OFF_CTRL, {24'h0, cb});
    repeat (8) @(posedge pclk);
    cur = e;
    chk_out(e);
  endtask
  // Nothing may move for four edges; the sixth shows the new state.
  task automatic step(input logic [15:0] v, input logic [2:0] e);
    srcv <= v;
    repeat (4) @(posedge pclk);
    chk_out(cur);
    repeat (2) @(posedge pclk);
    chk_out(e);
    cur = e;
  endtask
  task automatic count_hi(input int b, output int cnt);
    cnt = 0;
    repeat (20) begin
      @(posedge pclk);
      cnt += int'(outs[b]);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    $display("unexpected run length: expected end seen timeout");
    end_sim();
  end
  initial begin
    fail_count = 0;
    compares = 0;
    lfsr = 8'h62;
    {psel, penable, pwrite, perr} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    srcv = 16'h0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `RGS_OFF_OSLEN, 32'h0);
    chk_reg("length", 32'(`RGS_ONE_PULSE_CYC), rdat);
    apb(1'b0, 8'h10, 32'h0);
    chk_reg("refused", 32'h1, {31'h0, perr});
    chk_reg("refused data", 32'h0, rdat);
    apb(1'b1, `RGS_OFF_STAT, 32'hff);
    chk_reg("read only", 32'h0, {31'h0, perr});
    lfsr = lfsr_next(lfsr);
    apb(1'b1, `RGS_OFF_CTRL, {24'h0, lfsr});
    apb(1'b0, `RGS_OFF_CTRL, 32'h0);
    chk_reg("ctrl", {24'h0, lfsr}, rdat);
    // Lane 1 alone: only the fall index may change, reserved bits read 0.
    pstrb <= 4'h2;
    apb(1'b1, `RGS_OFF_SEL, 32'h0000_f5f5);
    pstrb <= 4'hf;
    apb(1'b0, `RGS_OFF_SEL, 32'h0);
    chk_reg("select", 32'h0000_0500, rdat);
    // Every source index drives the fall request; the rise source stays low, others carry noise.
    setup(8'h01, 16'h0, 3'b000);
    for (k = 0; k < 16; k++) begin
      apb(1'b1, `RGS_OFF_SEL, 32'((k + 1) % 16) | 32'(k << 8));
      m = 16'(1 << k) | 16'(1 << ((k + 1) % 16));
      lfsr = lfsr_next(lfsr);
      step(({lfsr, ~lfsr} & ~m) | 16'(1 << k), 3'b001);
      step(16'h0, 3'b000);
    end
    // Fall, rise and spare modes, plain and inverted: rise, fall, both.
    apb(1'b1, `RGS_OFF_SEL, 32'h0908);
    for (n = 0; n < 8; n++) begin
      if (n % 4 == 2) continue;
      m = (n >= 4) ? 16'hffff : 16'h0;
      setup((n >= 4 ? 8'hc0 : 8'h00) | 8'(2 * (n % 4) + 1), m, 3'b000);
      for (k = 1; k < 4; k++) begin
        step(m ^ 16'(k << 8), model(n % 4, k % 2, k / 2));
      end
      chk_reg("cap level", 32'h0, 32'(level));
      apb(1'b0, `RGS_OFF_STAT, 32'h0);
      chk_reg("status", {29'h0, cur}, {29'h0, rdat[2:0]});
      step(m, 3'b000);
    end
    // Alternating: starts up, turns at fall, turns back at rise.
    setup(8'h05, 16'h0, 3'b010);
    step(16'h0200, 3'b100);
    // Status: down, fall level high, rise level low, not busy.
    apb(1'b0, `RGS_OFF_STAT, 32'h0);
    chk_reg("status flags", 32'h8, {28'h0, rdat[6:3]});
    step(16'h0000, 3'b100);
    step(16'h0100, 3'b010);
    // Four-cycle one-shot; rise arrives while it runs, as level then edge.
    apb(1'b1, `RGS_OFF_OSLEN, 32'h4);
    for (k = 0; k < 2; k++) begin
      setup(8'h09 | 8'(k << 4), 16'h0, 3'b000);
      srcv <= 16'h0200;
      repeat (3) @(posedge pclk);
      srcv <= 16'h0100;
      count_hi(0, c);
      chk_reg("short span", 32'h1, 32'(c >= 4));
      chk_out(k == 1 ? 3'b000 : 3'b100);
    end
    // Alternating with one-shot: the down ramp may not turn early.
    setup(8'h0d, 16'h0, 3'b010);
    srcv <= 16'h0200;
    repeat (3) @(posedge pclk);
    srcv <= 16'h0100;
    count_hi(2, c);
    chk_reg("down span", 32'h1, 32'(c >= 4));
    chk_out(3'b010);
    end_sim();
  end
endmodule
bind rgs_ramp_ctrl rgs_ramp_ctrl_chk rgs_ramp_ctrl_chk_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ramp_short(ramp_short),
  .ramp_src_en(ramp_src_en), .ramp_sink_en(ramp_sink_en));
`default_nettype wire
